// >>> include/lpm_pkg.sv
// Package for the low-power mode controller: register map, fields, states
package lpm_pkg;
  localparam logic [7:0] LPM_CTRL_ADDR = 8'h00;
  localparam logic [7:0] LPM_STAT_ADDR = 8'h04;
  localparam logic [7:0] LPM_GATE_ADDR = 8'h08;
  localparam int CTRL_STOP_ALLOW = 0;
  localparam int CTRL_REF_KEEP = 1;
  localparam int CTRL_LVD_ON = 2;
  localparam int CTRL_LVD_STOP_ON = 3;
  localparam int CTRL_TMR_EN = 4;
  localparam int CTRL_CMP_EN = 5;
  localparam int CTRL_WKT_EN = 6;
  localparam int CTRL_WKT_STOP = 7;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int WAKE_CYCLES = 2;
  typedef enum logic [1:0]
  {
    LPM_RUN = 2'b00,
    LPM_WAIT = 2'b01,
    LPM_STOP = 2'b11,
    LPM_WAKE = 2'b10
  } lpm_state_e;
endpackage

// >>> rtl/lpm_sync.sv
// Three-stage input synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module lpm_sync
  import lpm_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;

  // First stage read only by the second
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        dout <= s3;
    end
  end
endmodule // lpm_sync
`default_nettype wire

// >>> rtl/lpm_ctrl.sv
// Low-power mode controller: wait/stop sequencing, clock and regulator gating, AHB-Lite registers
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int WAKE_DELAY = WAKE_CYCLES
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic waitExec,
  input wire logic stopExec,
  input wire logic irqPin,
  input wire logic irqCore,
  output logic cpuClkOn,
  output logic pcHold,
  output logic pcAdvance,
  output logic illegalReset,
  output logic regulatorOn,
  output logic clockSourceOn,
  output logic busClkOn,
  output logic timerClkOn,
  output logic compClkOn,
  output logic wakeTimerClkOn,
  output logic ioHold
);
  logic [CTRL_W-1:0] ctrl;
  lpm_state_e state;
  lpm_state_e next_state;
  logic fromStop;
  logic [7:0] wakeCnt;
  logic irqSync;
  logic irqAny;
  logic dWrite;
  logic [7:0] dAddr;
  logic keepSource;

  // Pin interrupt comes from outside the clock domain
  lpm_sync u_irq_sync
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .din(irqPin),
    .dout(irqSync)
  );

  assign irqAny = irqSync | irqCore;
  // Source kept only with all three keep bits set
  assign keepSource = ctrl[CTRL_REF_KEEP] & ctrl[CTRL_LVD_ON] & ctrl[CTRL_LVD_STOP_ON];

  // AHB-Lite address phase capture; always zero wait states
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dWrite <= 1'b0;
      dAddr <= 8'h00;
    end
    else if (hready)
    begin
      dWrite <= hsel & htrans[1] & hwrite & (hsize == HSIZE_WORD);
      dAddr <= haddr[7:0];
    end
  end

  // Control register write; steers gating decisions
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= CTRL_RESET;
    else if (dWrite && dAddr == LPM_CTRL_ADDR)
      ctrl <= hwdata[CTRL_W-1:0];
  end

  // Read data mux; unmapped reads zero, response always OKAY
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite)
      begin
        case (haddr[7:0])
          LPM_CTRL_ADDR: hrdata <= {24'h0, ctrl};
          LPM_STAT_ADDR: hrdata <= {29'h0, fromStop, state};
          LPM_GATE_ADDR: hrdata <= {24'h0, ioHold, wakeTimerClkOn, compClkOn, timerClkOn,
                                    busClkOn, clockSourceOn, regulatorOn, cpuClkOn};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Mode sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      LPM_RUN:
      begin
        if (stopExec && ctrl[CTRL_STOP_ALLOW])
          next_state = LPM_STOP;
        else if (waitExec && !stopExec)
          next_state = LPM_WAIT;
      end
      LPM_WAIT:
        if (irqAny)
          next_state = LPM_WAKE;
      LPM_STOP:
        if (irqAny)
          next_state = LPM_WAKE;
      LPM_WAKE:
        if (wakeCnt == 8'(WAKE_DELAY - 1))
          next_state = LPM_RUN;
      default: next_state = LPM_RUN;
    endcase
  end

  // State register; device reset returns to run for vector fetch
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= LPM_RUN;
    else
      state <= next_state;
  end

  // Remember which mode is being left
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      fromStop <= 1'b0;
    else if (state == LPM_STOP)
      fromStop <= 1'b1;
    else if (state == LPM_WAIT)
      fromStop <= 1'b0;
  end

  // Wake settling counter
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      wakeCnt <= 8'h00;
    else if (state == LPM_WAKE)
      wakeCnt <= wakeCnt + 8'h01;
    else
      wakeCnt <= 8'h00;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      illegalReset <= 1'b0;
    else
      illegalReset <= (state == LPM_RUN) & stopExec & ~ctrl[CTRL_STOP_ALLOW];
  end

  // Resume pulse; PC advances past halt point
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pcAdvance <= 1'b0;
    else
      pcAdvance <= (state == LPM_WAKE) && (next_state == LPM_RUN);
  end

  // Clock and power gating, registered so outputs never glitch
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpuClkOn <= 1'b1;
      pcHold <= 1'b0;
      regulatorOn <= 1'b1;
      clockSourceOn <= 1'b1;
      busClkOn <= 1'b1;
      timerClkOn <= 1'b1;
      compClkOn <= 1'b1;
      wakeTimerClkOn <= 1'b1;
      ioHold <= 1'b0;
    end
    else
    begin
      cpuClkOn <= (next_state == LPM_RUN);
      pcHold <= (next_state != LPM_RUN);
      ioHold <= (next_state == LPM_WAIT) || (next_state == LPM_STOP);
      regulatorOn <= (next_state != LPM_STOP);
      busClkOn <= (next_state != LPM_STOP);
      clockSourceOn <= (next_state != LPM_STOP) || keepSource;
      timerClkOn <= (next_state != LPM_STOP) && ((next_state == LPM_RUN) || ctrl[CTRL_TMR_EN]);
      compClkOn <= (next_state == LPM_RUN) || ((next_state == LPM_WAIT) && ctrl[CTRL_CMP_EN]) ||
                   ((next_state == LPM_STOP) && ctrl[CTRL_CMP_EN] && keepSource);
      wakeTimerClkOn <= (next_state == LPM_RUN) || ((next_state == LPM_WAIT) && ctrl[CTRL_WKT_EN]) ||
                        ((next_state == LPM_STOP) && ctrl[CTRL_WKT_STOP]);
    end
  end

  chk_stop_illegal: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_RUN && stopExec && !ctrl[CTRL_STOP_ALLOW]) |=> illegalReset && state == LPM_RUN)
    else $error("disallowed stop did not reset");
  chk_stop_gates: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_STOP) |-> !regulatorOn && !busClkOn && !cpuClkOn)
    else $error("stop left clocks running");
  // Source off unless three bits set
  chk_source_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_STOP && $stable(ctrl)) |-> (clockSourceOn == keepSource))
    else $error("clock source wrong in stop");
  chk_wait_cpu: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_WAIT) |-> !cpuClkOn && pcHold && regulatorOn && clockSourceOn)
    else $error("wait did not gate cpu");
  chk_wait_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_WAIT && !irqAny) |=> state == LPM_WAIT)
    else $error("wait left without interrupt");
  chk_wake_advance: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_STOP && irqAny) |-> ##[1:8] pcAdvance)
    else $error("no resume after stop interrupt");
  chk_clk_first: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(cpuClkOn) |-> regulatorOn && busClkOn && $past(regulatorOn))
    else $error("cpu clocked before regulator");
  chk_timer_stop: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_STOP) |-> !timerClkOn)
    else $error("timer running in stop");
  chk_io_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_WAIT || state == LPM_STOP) |-> ioHold)
    else $error("pins not held");
  chk_wait_resume: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_WAIT && irqAny) |-> ##[1:8] (pcAdvance && cpuClkOn))
    else $error("no resume after wait interrupt");
  chk_wake_power: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state == LPM_WAKE) |-> regulatorOn && busClkOn && !cpuClkOn && pcHold)
    else $error("cpu clocked before power was back");
  chk_advance_run: assert property (@(posedge core_clk) disable iff (!arst_n)
    pcAdvance |-> state == LPM_RUN && cpuClkOn && !pcHold)
    else $error("pc advanced while halted");
  chk_refused_run: assert property (@(posedge core_clk) disable iff (!arst_n)
    illegalReset |-> state == LPM_RUN && cpuClkOn && !ioHold)
    else $error("refused stop left run mode");

  // Main mode transitions, refused stop and clock source kept in stop reached
  cov_wait_exit: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == LPM_WAIT ##1 state == LPM_WAKE);
  cov_stop_exit: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == LPM_STOP ##1 state == LPM_WAKE);
  cov_illegal: cover property (@(posedge core_clk) disable iff (!arst_n) illegalReset);
  cov_keep_src: cover property (@(posedge core_clk) disable iff (!arst_n)
    state == LPM_STOP && clockSourceOn);
  cov_wake_run: cover property (@(posedge core_clk) disable iff (!arst_n) pcAdvance);
endmodule // lpm_ctrl
`default_nettype wire

// >>> bench/lpm_cpu_model.sv
// CPU core model: issues wait and stop opcodes, counts resumes
`timescale 1ns/1ns
`default_nettype none
module lpm_cpu_model
  import lpm_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [1:0] cmd,
  input wire logic cpuClkOn,
  input wire logic pcAdvance,
  output logic waitExec,
  output logic stopExec,
  output logic [7:0] resumes
);
  // One-cycle opcode pulse; a gated core executes nothing
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitExec <= 1'b0;
      stopExec <= 1'b0;
    end
    else
    begin
      waitExec <= cpuClkOn && cmd == 2'h1;
      stopExec <= cpuClkOn && cmd == 2'h2;
    end
  end
  // Each resume pulse adds one to the resume count
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      resumes <= 8'h00;
    else
      resumes <= resumes + {7'h00, pcAdvance};
  end
endmodule // lpm_cpu_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ns
`default_nettype none
module tb
  import lpm_pkg::*;
;
  logic core_clk, arst_n, hsel, hwrite, irqPin, irqCore, waitExec, stopExec;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, cmd;
  logic [2:0] hsize;
  logic hreadyout, hresp, cpuClkOn, pcHold, pcAdvance, illegalReset, regulatorOn, clockSourceOn;
  logic busClkOn, timerClkOn, compClkOn, wakeTimerClkOn, ioHold;
  logic [7:0] c, v, n, resumes;
  wire [7:0] gate;
  int nMismatch = 0, checksDone = 0, nIll = 0, op, k, ill;
  integer seed = 32'h335894ff;
  logic lastStop = 1'b0;
  // Enables gathered in the same order as the gate register
  assign gate = {ioHold, wakeTimerClkOn, compClkOn, timerClkOn, busClkOn, clockSourceOn, regulatorOn, cpuClkOn};
  lpm_ctrl #(.WAKE_DELAY(WAKE_CYCLES)) lpm_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .waitExec(waitExec), .stopExec(stopExec),
    .irqPin(irqPin), .irqCore(irqCore), .cpuClkOn(cpuClkOn), .pcHold(pcHold), .pcAdvance(pcAdvance),
    .illegalReset(illegalReset), .regulatorOn(regulatorOn), .clockSourceOn(clockSourceOn),
    .busClkOn(busClkOn), .timerClkOn(timerClkOn), .compClkOn(compClkOn), .wakeTimerClkOn(wakeTimerClkOn),
    .ioHold(ioHold));
  lpm_cpu_model lpm_cpu_model_i (.core_clk(core_clk), .arst_n(arst_n), .cmd(cmd), .cpuClkOn(cpuClkOn),
    .pcAdvance(pcAdvance), .waitExec(waitExec), .stopExec(stopExec), .resumes(resumes));
  // Free-running 20 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Pulse seen mid-cycle so no edge race
  always @(negedge core_clk)
    if (illegalReset === 1'b1) nIll++;
  task automatic report_and_stop;
    if (nMismatch == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Enables per mode: o 1 wait, 2 stop, else run or refused stop
  function automatic logic [7:0] expGate(input int o, input logic [7:0] b);
    logic kp;
    kp = &b[3:1];
    if (o == 1) return {1'b1, b[6], b[5], b[4], 4'he};
    if (o == 2 && b[0]) return {1'b1, b[7], b[5] & kp, 2'h0, kp, 2'h0};
    return 8'h7f;
  endfunction
  // Status word: last exit from stop over the mode code
  function automatic logic [31:0] expStat(input int o, input logic s, input logic fs);
    if (o == 1) return {29'h0, 1'b0, LPM_WAIT};
    if (o == 2 && s) return {29'h0, 1'b1, LPM_STOP};
    return {29'h0, fs, LPM_RUN};
  endfunction
  // Watchdog sized well above the whole sequence
  initial
  begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    report_and_stop();
  end
  initial
  begin
    {arst_n, hsel, hwrite, irqPin, irqCore, haddr, hwdata, htrans, cmd} = '0;
    hsize = HSIZE_WORD;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    cmp("gate", 8'h7f, gate);
    xfer(1'b0, 8'h0c, 32'h0);
    cmp("unmapped", 32'h0, rd);
    repeat (3)
    begin
      v = 8'($random(seed));
      xfer(1'b1, LPM_CTRL_ADDR, {24'h0, v});
      xfer(1'b0, LPM_CTRL_ADDR, 32'h0);
      cmp("ctrl", {24'h0, v}, rd);
    end
    // Corner cases: refused stop, both wake sources, all keep bits
    for (int i = 0; i < 6; i++)
    begin
      op = (i == 0 || i == 3) ? 1 : 2;
      c = 8'($random(seed));
      c[0] = (i != 1);
      if (i == 5) c[3:1] = 3'b111;
      ill = nIll;
      n = resumes;
      xfer(1'b1, LPM_CTRL_ADDR, {24'h0, c});
      @(posedge core_clk);
      cmd <= op[1:0];
      @(posedge core_clk);
      cmd <= 2'h0;
      repeat (25) @(negedge core_clk);
      cmp("illegal", {31'h0, op == 2 && !c[0]}, nIll - ill);
      cmp("gate", expGate(op, c), gate);
      cmp("pcHold", {31'h0, op == 1 || c[0]}, pcHold);
      xfer(1'b0, LPM_GATE_ADDR, 32'h0);
      cmp("gate reg", {24'h0, expGate(op, c)}, rd);
      xfer(1'b0, LPM_STAT_ADDR, 32'h0);
      cmp("stat", expStat(op, c[0], lastStop), rd);
      if (op == 1) lastStop = 1'b0;
      else if (c[0]) lastStop = 1'b1;
      if (op == 1 || c[0])
      begin
        @(posedge core_clk);
        if (i[0]) irqPin <= 1'b1;
        else irqCore <= 1'b1;
        for (k = 0; k < 30 && pcAdvance !== 1'b1; k++) @(negedge core_clk);
        cmp("wake gate", 8'h7f, gate);
        @(posedge core_clk);
        irqPin <= 1'b0;
        irqCore <= 1'b0;
        @(negedge core_clk);
        cmp("resume", n + 1, resumes);
        repeat (4) @(posedge core_clk);
      end
    end
    // Reset in mid-wait returns the core to run
    @(posedge core_clk);
    cmd <= 2'h1;
    @(posedge core_clk);
    cmd <= 2'h0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b0;
    @(negedge core_clk);
    cmp("reset gate", 8'h7f, gate);
    @(posedge core_clk);
    arst_n <= 1'b1;
    // After release: run gating, run state, cleared control
    @(negedge core_clk);
    cmp("gate", 8'h7f, gate);
    xfer(1'b0, LPM_STAT_ADDR, 32'h0);
    cmp("reset stat", 32'h0, rd);
    xfer(1'b0, LPM_CTRL_ADDR, 32'h0);
    cmp("reset ctrl", {24'h0, CTRL_RESET}, rd);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
